/* File: verilog/anps_pkg.sv */
// Package for the auto-negotiation partner page status registers.
// Assumes a management-register front end that presents register address and read strobe.
package anps_pkg;
   localparam logic [4:0] ANPS_ADDR_PARTNER = 5'h05;
   localparam logic [4:0] ANPS_ADDR_EXPANSION = 5'h06;
   localparam int ANPS_BIT_FURTHER = 15;
   localparam int ANPS_BIT_ACK = 14;
   localparam int ANPS_BIT_MSG = 13;
   localparam int ANPS_BIT_COMPLY = 12;
   localparam int ANPS_BIT_TOGGLE = 11;
   localparam int ANPS_BIT_PDF = 4;
   localparam int ANPS_BIT_LPNP = 3;
   localparam int ANPS_BIT_LOCNP = 2;
   localparam int ANPS_BIT_PAGE = 1;
   localparam int ANPS_BIT_LPAN = 0;
   localparam logic [15:0] ANPS_PARTNER_RESET = 16'h0000;
   localparam logic [15:0] ANPS_DATA_ZERO = 16'h0000;
   typedef struct packed {
      logic [15:0] partner_word;
      logic parallel_detect_fault;
      logic partner_next_page_capable;
      logic page_received;
      logic partner_autoneg_capable;
      logic [15:0] rdata;
   } anps_state_t;
endpackage

/* File: verilog/anps_status.sv */
// Partner next-page word and expansion status registers, read over management access.
// Assumes the auto-negotiation logic and register front end share CLK.
`timescale 1ns/1ps
`default_nettype none
module anps_status
   import anps_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // Auto-negotiation side
   input wire logic PAGE_VALID,
   input wire logic [15:0] PAGE_WORD,
   input wire logic PARALLEL_DETECT_FAULT,
   input wire logic PARTNER_NEXT_PAGE_CAPABLE,
   input wire logic PARTNER_AUTONEG_CAPABLE,
   // Management register access
   input wire logic RD_EN,
   input wire logic [4:0] RD_ADDR,
   output logic [15:0] RD_DATA
);
   import anps_pkg::*;

   // Register image: partner word, status flags and the registered read data
   anps_state_t st;
   anps_state_t next_st;

   // Decoded read requests for the two mapped registers
   logic read_partner;
   logic read_expansion;

   // Named views of the incoming partner page
   logic page_further;
   logic page_ack;
   logic page_message;
   logic page_comply;
   logic page_toggle;
   logic [10:0] page_code;

   // Assembled partner word as it will be stored
   logic [15:0] page_assembled;

   // Read data that the next edge will present
   logic [15:0] read_value;

   // True when a read strobe addresses the given register
   function automatic logic reads_reg(
      input logic en,
      input logic [4:0] addr,
      input logic [4:0] target
   );
      logic hit;
      hit = en && (addr == target);
      return hit;
   endfunction

   // Rebuild the partner word from its fields; the arbitration logic
   // already hands them over in link code word order
   function automatic logic [15:0] partner_word_of(
      input logic further,
      input logic ack,
      input logic message,
      input logic comply,
      input logic toggle,
      input logic [10:0] code
   );
      logic [15:0] w;
      w = ANPS_PARTNER_RESET;
      w[ANPS_BIT_FURTHER] = further;
      w[ANPS_BIT_ACK] = ack;
      w[ANPS_BIT_MSG] = message;
      w[ANPS_BIT_COMPLY] = comply;
      w[ANPS_BIT_TOGGLE] = toggle;
      w[ANPS_BIT_TOGGLE-1:0] = code;
      return w;
   endfunction

   // Expansion register image; reserved bits are forced low here so
   // no future field can leak into them by accident
   function automatic logic [15:0] expansion_word(input anps_state_t s);
      logic [15:0] w;
      w = ANPS_DATA_ZERO;
      w[ANPS_BIT_PDF] = s.parallel_detect_fault;
      w[ANPS_BIT_LPNP] = s.partner_next_page_capable;
      w[ANPS_BIT_LOCNP] = 1'b1;
      w[ANPS_BIT_PAGE] = s.page_received;
      w[ANPS_BIT_LPAN] = s.partner_autoneg_capable;
      return w;
   endfunction

   // Read multiplexer; unmapped addresses and idle cycles give zero
   function automatic logic [15:0] read_data_of(
      input anps_state_t s,
      input logic part,
      input logic expn
   );
      logic [15:0] d;
      d = ANPS_DATA_ZERO;
      if (part)
      begin
         d = s.partner_word;
      end
      else if (expn)
      begin
         d = expansion_word(s);
      end
      return d;
   endfunction

   // Address decode, shared by the read path and the read-clear of the page flag
   assign read_partner = reads_reg(RD_EN, RD_ADDR, ANPS_ADDR_PARTNER);
   assign read_expansion = reads_reg(RD_EN, RD_ADDR, ANPS_ADDR_EXPANSION);

   // Field split of the incoming page
   assign page_further = PAGE_WORD[ANPS_BIT_FURTHER];
   assign page_ack = PAGE_WORD[ANPS_BIT_ACK];
   assign page_message = PAGE_WORD[ANPS_BIT_MSG];
   assign page_comply = PAGE_WORD[ANPS_BIT_COMPLY];
   assign page_toggle = PAGE_WORD[ANPS_BIT_TOGGLE];
   assign page_code = PAGE_WORD[ANPS_BIT_TOGGLE-1:0];

   assign page_assembled = partner_word_of(
      page_further,
      page_ack,
      page_message,
      page_comply,
      page_toggle,
      page_code
   );

   // The read sees the register image of this cycle, so the page flag
   // returned is the value from before the clear
   assign read_value = read_data_of(st, read_partner, read_expansion);

   always_comb
   begin
      next_st = st;

      // Fault is sticky: only reset removes it
      next_st.parallel_detect_fault = st.parallel_detect_fault | PARALLEL_DETECT_FAULT;

      // Capability levels follow the arbitration logic with one cycle lag
      next_st.partner_next_page_capable = PARTNER_NEXT_PAGE_CAPABLE;
      next_st.partner_autoneg_capable = PARTNER_AUTONEG_CAPABLE;

      // Partner word is loaded only on a new page and held otherwise
      if (PAGE_VALID)
      begin
         next_st.partner_word = page_assembled;
      end

      // Registered read data keeps the output straight from a flip-flop
      next_st.rdata = read_value;

      // Read of the expansion register clears the page flag
      if (read_expansion)
      begin
         next_st.page_received = 1'b0;
      end

      // A page arriving in the reading cycle must not be lost, so set wins
      if (PAGE_VALID)
      begin
         next_st.page_received = 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         st <= '{ANPS_PARTNER_RESET, 1'b0, 1'b0, 1'b0, 1'b0, ANPS_DATA_ZERO};
      end
      else
      begin
         st <= next_st;
      end
   end

   // Output taken from the state register only
   assign RD_DATA = st.rdata;
endmodule
`default_nettype wire

/* File: dv/anps_mgmt.sv */
// Management master model that issues register reads.
// Assumes read data appears one edge after the request is driven.
`timescale 1ns/1ps
`default_nettype none
module anps_mgmt (input wire logic CLK, input wire logic [15:0] RD_DATA,
   output logic RD_EN = 0, output logic [4:0] RD_ADDR = 0);
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge CLK) {RD_EN, RD_ADDR} <= {1'h1, a};
      // Released address is inverted so a stale value cannot pass
      @(posedge CLK) {RD_EN, RD_ADDR} <= {1'h0, ~a};
      #1 d = RD_DATA;
   endtask
endmodule
`default_nettype wire

/* File: dv/anps_status_checker.sv */
// Read port assertions for the partner page status block.
// Assumes binding onto anps_status, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module anps_checker (input wire logic CLK, NRST, PAGE_VALID, RD_EN, PARALLEL_DETECT_FAULT,
   input wire logic [4:0] RD_ADDR, input wire logic [15:0] PAGE_WORD, RD_DATA);
   logic [15:0] w;
   wire x = RD_EN && RD_ADDR == 5'h06, u = !(RD_ADDR inside {5'h05, 5'h06});
   wire p = RD_EN && RD_ADDR == 5'h05 && !PAGE_VALID, v = PAGE_VALID, f = PARALLEL_DETECT_FAULT;
   always_ff @(posedge CLK or negedge NRST) w <= !NRST ? 16'h0000 : v ? PAGE_WORD : w;
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   idle_zero_a: assert property (!RD_EN || u |=> !RD_DATA) else $error("idle");
   upper_zero_a: assert property (x |=> !RD_DATA[15:5]) else $error("upper");
   fixed_one_a: assert property (x |=> RD_DATA[2]) else $error("fixed");
   fault_seen_a: assert property (f ##2 x |=> RD_DATA[4]) else $error("fault");
   page_set_a: assert property (v ##1 !x ##1 x |=> RD_DATA[1]) else $error("set");
   page_clr_a: assert property (!v throughout x ##2 x |=> !RD_DATA[1]) else $error("clr");
   word_flags_a: assert property (p |=> RD_DATA[15:11] == $past(w[15:11])) else $error("w");
   word_code_a: assert property (p |=> RD_DATA[10:0] == $past(w[10:0])) else $error("c");
endmodule
bind anps_status anps_checker anps_checker_i(.*);
`default_nettype wire

/* File: dv/anps_status_test.sv */
// Self-checking bench reading both status registers through the model.
// Assumes the checker binds itself onto the design.
`timescale 1ns/1ps
`default_nettype none
module anps_status_test;
   logic CLK = 0, NRST = 0, PAGE_VALID = 0, RD_EN, PARALLEL_DETECT_FAULT = 0;
   logic PARTNER_NEXT_PAGE_CAPABLE = 0, PARTNER_AUTONEG_CAPABLE = 0;
   logic [15:0] PAGE_WORD = 0, RD_DATA, d;
   logic [4:0] RD_ADDR;
   int bad_count = 0, comparisons = 0;
   anps_status anps_status_i(.*);
   anps_mgmt anps_mgmt_i(.*);
   initial forever #12.5 CLK = ~CLK;
   task automatic chk(input logic [4:0] a, input logic [15:0] e);
      anps_mgmt_i.rd(a, d);
      comparisons++;
      if (d !== e) $display("wrong value %0t reg %h got %h", $time, a, d);
      bad_count += int'(d !== e);
   endtask
   task automatic pg(input logic [18:0] s);
      @(posedge CLK) {PARALLEL_DETECT_FAULT, PARTNER_NEXT_PAGE_CAPABLE,
         PARTNER_AUTONEG_CAPABLE, PAGE_WORD, PAGE_VALID} <= {s, 1'h1};
      @(posedge CLK) {PARALLEL_DETECT_FAULT, PAGE_VALID} <= 2'h0;
   endtask
   task automatic conclude;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge CLK);
      NRST <= 1;
      chk(5'h06, 16'h0004);
      chk(5'h05, 16'h0000);
      pg(19'h0A9C3);
      chk(5'h05, 16'hA9C3);
      chk(5'h06, 16'h0006);
      chk(5'h06, 16'h0004);
      pg(19'h75234);
      chk(5'h06, 16'h001F);
      chk(5'h06, 16'h001D);
      chk(5'h05, 16'h5234);
      chk(5'h07, 16'h0000);
      @(posedge CLK) NRST <= 0;
      @(posedge CLK) NRST <= 1;
      chk(5'h06, 16'h000D);
      chk(5'h05, 16'h0000);
      conclude;
   end
endmodule
`default_nettype wire
